// [hdl/sbsr_params.svh]
`ifndef SBSR_PARAMS_SVH
`define SBSR_PARAMS_SVH
// ----------------------------------------------------------------------------
// Status byte layout and reset values
// ----------------------------------------------------------------------------
`define SBSR_BIT_ERRQ       2
`define SBSR_BIT_QUES       3
`define SBSR_BIT_MAV        4
`define SBSR_BIT_ESB        5
`define SBSR_BIT_MSS        6
`define SBSR_BIT_OPER       7
`define SBSR_SUMMARY_MASK   8'hBC
`define SBSR_MASK_RESET     8'h00
`define SBSR_STAT_RESET     8'h00
`define SBSR_QUES_WIDTH     16
`define SBSR_OPER_WIDTH     16
`define SBSR_ESR_WIDTH      8
`define SBSR_SRQ_HOLD_CYC   1
`endif

// [hdl/sbsr_pkg.sv]
package sbsr_pkg;
  // Status byte and enable mask are both one byte wide.
  typedef logic [7:0]  sbsr_byte_t;
  // Questionable and operation registers are sixteen bits wide; the event status register is eight.
  typedef logic [15:0] sbsr_word_t;
  // Command codes carried on the command port.
  typedef enum logic [2:0] {
    SBSR_CMD_NONE     = 3'b000,
    SBSR_CMD_STB_QRY  = 3'b001,
    SBSR_CMD_POLL     = 3'b010,
    SBSR_CMD_SRE_SET  = 3'b011,
    SBSR_CMD_SRE_QRY  = 3'b100
  } sbsr_cmd_t;
endpackage : sbsr_pkg

// [hdl/sbsr_sum.sv]
`timescale 1ns/1ps
`include "sbsr_params.svh"
// ----------------------------------------------------------------------------
// Registered sum bit of one lower register: OR of event AND enable.
// ----------------------------------------------------------------------------
module sbsr_sum #(
  parameter int W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] event_bits,
  input  wire logic [W-1:0] enable_bits,
  output logic              sum_bit
);
  logic next_sum;  // Combined sum before registering.

  // The sum is ANDed per bit, then ORed across the word.
  always_comb begin
    next_sum = |(event_bits & enable_bits);
  end

  // Register the sum so the status byte sees a clean level.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sum_bit <= 1'b0;
    end else if (ce) begin
      sum_bit <= next_sum;
    end
  end
endmodule : sbsr_sum

// [hdl/sbsr_top.sv]
`timescale 1ns/1ps
`include "sbsr_params.svh"
module sbsr_top
  import sbsr_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic                ce,
  input  wire logic [15:0]         ques_event,
  input  wire logic [15:0]         ques_enable,
  input  wire logic [15:0]         oper_event,
  input  wire logic [15:0]         oper_enable,
  input  wire logic [7:0]          esr_event,
  input  wire logic [7:0]          esr_enable,
  input  wire logic                errq_not_empty,
  input  wire logic                errq_push,
  input  wire logic                out_msg_avail,
  input  wire sbsr_pkg::sbsr_cmd_t cmd,
  input  wire sbsr_pkg::sbsr_byte_t cmd_data,
  output sbsr_pkg::sbsr_byte_t     rsp_data,
  output logic                     rsp_valid,
  output logic                     srq_pulse,
  output logic                     service_req
);
  import sbsr_pkg::*;

  // --------------------------------------------------------------------------
  // Lower-level sum bits
  // --------------------------------------------------------------------------
  logic ques_sum;  // Questionable summary.
  logic oper_sum;  // Operation summary.
  logic esb_sum;   // Event status summary.

  sbsr_sum #(.W(`SBSR_QUES_WIDTH)) u_ques (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .ce          (ce),
    .event_bits  (ques_event),
    .enable_bits (ques_enable),
    .sum_bit     (ques_sum)
  );
  sbsr_sum #(.W(`SBSR_OPER_WIDTH)) u_oper (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .ce          (ce),
    .event_bits  (oper_event),
    .enable_bits (oper_enable),
    .sum_bit     (oper_sum)
  );
  sbsr_sum #(.W(`SBSR_ESR_WIDTH)) u_esr (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .ce          (ce),
    .event_bits  (esr_event),
    .enable_bits (esr_enable),
    .sum_bit     (esb_sum)
  );

  // --------------------------------------------------------------------------
  // Status byte assembly and service request state
  // --------------------------------------------------------------------------
  sbsr_byte_t status_summary_byte;       // Condition byte, bit 6 is the summary.
  sbsr_byte_t service_request_mask;      // Software-written enable mask.
  sbsr_byte_t prev_cond;                 // Last cycle's condition bits.
  sbsr_byte_t next_status_summary_byte;
  sbsr_byte_t next_service_request_mask;
  sbsr_byte_t next_prev_cond;
  sbsr_byte_t cond;                      // Live condition bits without summary.
  sbsr_byte_t rise;                      // Enabled rising edges.
  logic       next_srq_pulse;
  logic       next_service_req;
  logic       mss;

  // Mask of bits that feed the summary; bits 0, 1 and 6 are out.
  function automatic sbsr_byte_t enabled_bits(input sbsr_byte_t c, input sbsr_byte_t m);
    enabled_bits = c & m & `SBSR_SUMMARY_MASK;
  endfunction : enabled_bits

  // Build the condition byte and decide on service requests.
  always_comb begin
    cond                     = `SBSR_STAT_RESET;
    cond[`SBSR_BIT_ERRQ]     = errq_not_empty | errq_push;
    cond[`SBSR_BIT_QUES]     = ques_sum;
    cond[`SBSR_BIT_MAV]      = out_msg_avail;
    cond[`SBSR_BIT_ESB]      = esb_sum;
    cond[`SBSR_BIT_OPER]     = oper_sum;
    mss                      = |enabled_bits(cond, service_request_mask);
    next_status_summary_byte = cond;
    next_status_summary_byte[`SBSR_BIT_MSS] = mss;
    // A rising edge is a request; a fresh error push counts as one even while
    // the queue already holds entries, so each entry is reported.
    rise = enabled_bits(cond & ~prev_cond, service_request_mask);
    next_srq_pulse = (|rise) |
                     (errq_push & service_request_mask[`SBSR_BIT_ERRQ]);
    next_prev_cond   = cond;
    next_service_req = mss;
    next_service_request_mask = service_request_mask;
    if (cmd == SBSR_CMD_SRE_SET) begin
      next_service_request_mask = cmd_data;
    end
  end

  // Register the status state.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      status_summary_byte  <= `SBSR_STAT_RESET;
      service_request_mask <= `SBSR_MASK_RESET;
      prev_cond            <= `SBSR_STAT_RESET;
      srq_pulse            <= 1'b0;
      service_req          <= 1'b0;
    end else if (ce) begin
      status_summary_byte  <= next_status_summary_byte;
      service_request_mask <= next_service_request_mask;
      prev_cond            <= next_prev_cond;
      srq_pulse            <= next_srq_pulse;
      service_req          <= next_service_req;
    end
  end

  // --------------------------------------------------------------------------
  // Command answers
  // --------------------------------------------------------------------------
  sbsr_byte_t next_rsp_data;
  logic       next_rsp_valid;

  // Queries answer one cycle later from the registered byte, or from the mask for the mask query.
  always_comb begin
    next_rsp_data  = rsp_data;
    next_rsp_valid = 1'b0;
    unique case (cmd)
      SBSR_CMD_STB_QRY, SBSR_CMD_POLL: begin
        next_rsp_data  = status_summary_byte;
        next_rsp_valid = 1'b1;
      end
      SBSR_CMD_SRE_QRY: begin
        next_rsp_data  = service_request_mask;
        next_rsp_valid = 1'b1;
      end
      default: begin
        next_rsp_valid = 1'b0;
      end
    endcase
  end

  // Register the answer.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rsp_data  <= `SBSR_STAT_RESET;
      rsp_valid <= 1'b0;
    end else if (ce) begin
      rsp_data  <= next_rsp_data;
      rsp_valid <= next_rsp_valid;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_low_zero;
    @(posedge core_clk) disable iff (!nrst) status_summary_byte[1:0] == 2'b00;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low bits set");
  property p_mss;
    @(posedge core_clk) disable iff (!nrst)
      status_summary_byte[`SBSR_BIT_MSS] == service_req;
  endproperty
  a_mss: assert property (p_mss) else $error("summary and request differ");
  property p_mask_set;
    @(posedge core_clk) disable iff (!nrst)
      (ce && cmd == SBSR_CMD_SRE_SET) |=> service_request_mask == $past(cmd_data);
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask not stored");
  property p_stb_qry;
    @(posedge core_clk) disable iff (!nrst)
      (ce && (cmd == SBSR_CMD_STB_QRY || cmd == SBSR_CMD_POLL))
        |=> rsp_valid && rsp_data == $past(status_summary_byte);
  endproperty
  a_stb_qry: assert property (p_stb_qry) else $error("status answer wrong");
  property p_errq;
    @(posedge core_clk) disable iff (!nrst)
      (ce && errq_push && service_request_mask[`SBSR_BIT_ERRQ]) |=> srq_pulse;
  endproperty
  a_errq: assert property (p_errq) else $error("error entry lost");
  property p_mav;
    @(posedge core_clk) disable iff (!nrst)
      (nrst && ce) |=> status_summary_byte[`SBSR_BIT_MAV] == $past(out_msg_avail);
  endproperty
  a_mav: assert property (p_mav) else $error("message bit wrong");
  property p_mask6;
    @(posedge core_clk) disable iff (!nrst)
      (ce && service_request_mask == 8'h40) |=> !service_req;
  endproperty
  a_mask6: assert property (p_mask6) else $error("bit six not ignored");
  property p_rise;
    @(posedge core_clk) disable iff (!nrst)
      (ce && out_msg_avail && !prev_cond[`SBSR_BIT_MAV]
       && service_request_mask[`SBSR_BIT_MAV]) |=> srq_pulse;
  endproperty
  a_rise: assert property (p_rise) else $error("rise missed");
endmodule : sbsr_top

// [tb/sbsr_rc.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Remote controller: one command, one answer for each query.
// ----------------------------------------
module sbsr_rc
  import sbsr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire sbsr_byte_t rsp_data,
  input  wire logic       rsp_valid,
  output sbsr_cmd_t       cmd,
  output sbsr_byte_t      cmd_data
);
  // Idle with no command before reset ends.
  initial begin
    cmd      = SBSR_CMD_NONE;
    cmd_data = 8'h00;
  end
  // Mask writes get no answer, so only queries wait; a lost answer reads as unknown.
  task automatic xfer(input sbsr_cmd_t c, input sbsr_byte_t d, output sbsr_byte_t r);
    int n;
    r = 8'hxx;
    @(posedge core_clk);
    cmd      <= c;
    cmd_data <= d;
    @(posedge core_clk);
    cmd      <= SBSR_CMD_NONE;
    cmd_data <= ~d;
    if (c != SBSR_CMD_SRE_SET) begin
      // The answer is taken at the edge where rsp_valid is sampled high.
      n = 0;
      @(posedge core_clk);
      while (rsp_valid !== 1'b1 && n < 4) begin
        @(posedge core_clk);
        n++;
      end
      if (rsp_valid === 1'b1) begin
        r = rsp_data;
      end
    end
  endtask : xfer
endmodule : sbsr_rc

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import sbsr_pkg::*;
  // ----------------------------------------
  // Stimulus and counters
  // ----------------------------------------
  logic core_clk, nrst, ce, errq_ne, errq_push, mav;
  logic [15:0] q_ev, q_en, o_ev, o_en;
  logic [7:0]  e_ev, e_en;
  sbsr_cmd_t   cmd;
  sbsr_byte_t  cmd_data, rsp_data, mask, r;
  logic        rsp_valid, srq_pulse, service_req;
  int          err_total, checked, cyc, srq_cnt, c0;
  sbsr_top DUT (.core_clk(core_clk), .nrst(nrst), .ce(ce), .ques_event(q_ev),
    .ques_enable(q_en), .oper_event(o_ev), .oper_enable(o_en), .esr_event(e_ev),
    .esr_enable(e_en), .errq_not_empty(errq_ne), .errq_push(errq_push),
    .out_msg_avail(mav), .cmd(cmd), .cmd_data(cmd_data), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .srq_pulse(srq_pulse), .service_req(service_req));
  sbsr_rc ctl (.core_clk(core_clk), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .cmd(cmd), .cmd_data(cmd_data));
  // Clock at 50 ns.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Count service request pulses and cut a hang short.
  always @(posedge core_clk) begin
    cyc++;
    if (srq_pulse === 1'b1) srq_cnt++;
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string w, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask : check
  // Status byte as the sources stand; bit 6 leaves itself out.
  function automatic sbsr_byte_t exp_stb(input sbsr_byte_t m);
    sbsr_byte_t s;
    s = {|(o_ev & o_en), 1'b0, |(e_ev & e_en), mav, |(q_ev & q_en), errq_ne, 2'b00};
    s[6] = |(s & m & 8'hBF);
    return s;
  endfunction : exp_stb
  task automatic src(input logic [15:0] qe, qn, oe, on, input logic [7:0] ee, en,
                     input logic ne, ma);
    @(posedge core_clk);
    {q_ev, q_en, o_ev, o_en, e_ev, e_en, errq_ne, mav} <= {qe, qn, oe, on, ee, en, ne, ma};
  endtask : src
  // Sums take two cycles to reach the byte; four leaves margin.
  task automatic chk_stb;
    sbsr_byte_t e;
    repeat (4) @(posedge core_clk);
    e = exp_stb(mask);
    ctl.xfer(SBSR_CMD_STB_QRY, 8'h00, r);
    check("status_byte", e, r);
    ctl.xfer(SBSR_CMD_POLL, 8'h00, r);
    check("poll", e, r);
    check("service_req", {7'h00, e[6]}, {7'h00, service_req});
  endtask : chk_stb
  task automatic set_mask(input sbsr_byte_t m);
    mask = m;
    ctl.xfer(SBSR_CMD_SRE_SET, m, r);
    ctl.xfer(SBSR_CMD_SRE_QRY, 8'h00, r);
    check("mask", m, r);
  endtask : set_mask
  task automatic push;
    @(posedge core_clk);
    errq_push <= 1'b1;
    @(posedge core_clk);
    errq_push <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : push
  task automatic complete_run;
    $display("Counts: checked %0d, errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {nrst, ce, errq_ne, errq_push, mav, q_ev, q_en, o_ev, o_en, e_ev, e_en} = '0;
    ce = 1'b1;
    mask = 8'h00;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    ctl.xfer(SBSR_CMD_SRE_QRY, 8'h00, r);
    check("mask_reset", 8'h00, r);
    chk_stb();
    $display("Test reset done");
    set_mask(8'hBF);
    src(16'h0208, 16'h0200, 0, 0, 0, 0, 0, 0); chk_stb();
    src(16'h0008, 16'h0200, 0, 0, 0, 0, 0, 0); chk_stb();
    src(0, 0, 16'h4001, 16'h0001, 0, 0, 0, 0); chk_stb();
    src(0, 0, 0, 0, 8'h20, 8'h20, 0, 0); chk_stb();
    src(0, 0, 0, 0, 8'h20, 8'hDF, 0, 0); chk_stb();
    src(0, 0, 0, 0, 0, 0, 0, 1); chk_stb();
    src(0, 0, 0, 0, 0, 0, 1, 0); chk_stb();
    set_mask(8'h40);
    src(16'h0001, 16'h0001, 16'h0001, 16'h0001, 8'h01, 8'h01, 1, 1); chk_stb();
    $display("Test status byte done");
    src(0, 0, 0, 0, 0, 0, 0, 0);
    c0 = srq_cnt;
    src(0, 0, 0, 0, 0, 0, 0, 1); chk_stb();
    check("srq_masked", 8'h00, 8'(srq_cnt - c0));
    src(0, 0, 0, 0, 0, 0, 0, 0);
    set_mask(8'h10);
    c0 = srq_cnt;
    src(0, 0, 0, 0, 0, 0, 0, 1); chk_stb();
    check("srq_mav", 8'h01, 8'(srq_cnt - c0));
    src(0, 0, 0, 0, 0, 0, 0, 0);
    set_mask(8'h04);
    src(0, 0, 0, 0, 0, 0, 1, 0);
    // The queue turning non-empty is a rise of its own; count only the pushes.
    repeat (3) @(posedge core_clk);
    c0 = srq_cnt;
    push(); push(); push(); chk_stb();
    check("srq_errq", 8'h03, 8'(srq_cnt - c0));
    // A mask write while the enable is low must leave the mask alone.
    ce <= 1'b0;
    ctl.xfer(SBSR_CMD_SRE_SET, 8'hFF, r);
    @(posedge core_clk);
    ce <= 1'b1;
    ctl.xfer(SBSR_CMD_SRE_QRY, 8'h00, r);
    check("mask_frozen", 8'h04, r);
    $display("Test service request done");
    complete_run();
  end
endmodule : tb_top
